// ### common/dsc_pkg.sv
package dsc_pkg;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned PUD_US        = 1500;
  localparam int unsigned SWITCH_US     = 150;
  localparam int unsigned PUD_CYC       = (PUD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SWITCH_CYC    = (SWITCH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MARGIN_CYC    = 16;
  localparam int unsigned RST_HOLD_CYC  = 16;
  localparam int unsigned GAP_CYC       = 4;
  localparam int unsigned HALF_CYC      = 8;
  localparam int unsigned IMP_PHASE_CYC = 1024;
  localparam int unsigned CNT_W         = 18;
  localparam int unsigned FRAME_BITS    = 16;
  // ---------------------------------------------------------------------------
  // link register map
  // ---------------------------------------------------------------------------
  localparam logic [6:0] A_PWR   = 7'h00;
  localparam logic [6:0] A_CLK   = 7'h01;
  localparam logic [6:0] A_ISTAT = 7'h02;
  localparam logic [6:0] A_IMASK = 7'h03;
  localparam logic [6:0] A_IMP   = 7'h04;
  localparam logic [6:0] A_IRES  = 7'h05;
  localparam logic [6:0] A_STAT  = 7'h06;
  localparam logic [6:0] A_SER   = 7'h07;
  localparam int unsigned PWR_PDN = 0;
  localparam int unsigned PWR_PLL = 1;
  localparam int unsigned PWR_BYP = 2;
  localparam logic [2:0] PWR_RST = 3'h1;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_OSC = 2'h2;
  localparam logic [1:0] SRC_BAD = 2'h3;
  localparam logic [1:0] FMT_BAD = 2'h3;
  localparam int unsigned CLK_SYSPLL = 2;
  localparam int unsigned IMP_START  = 7;
  localparam logic [2:0] MASK_RST = 3'h7;
  // ---------------------------------------------------------------------------
  // host wishbone map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] WB_CMD  = 4'h0;
  localparam logic [3:0] WB_STAT = 4'h4;
  localparam logic [3:0] WB_CTRL = 4'h8;
  typedef enum logic [1:0] {H_RESET, H_WAIT, H_IDLE, H_RUN} dsc_host_state_type;
endpackage

// ### common/dsc_link_if.sv
`timescale 1ns/1ps
interface dsc_link_if;
  logic reset_n;
  logic link_clk;
  logic frame;
  logic mosi;
  logic miso;
  logic int_n_o;
  logic int_n_oe;
  logic int_n;
  // open-drain with pull-up
  assign int_n = int_n_oe ? int_n_o : 1'b1;
  modport dev (input reset_n, link_clk, frame, mosi, output miso, int_n_o, int_n_oe);
  modport host (output reset_n, link_clk, frame, mosi, input miso, int_n);
endinterface

// ### logic/dsc_sync.sv
`timescale 1ns/1ps
module dsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// ### logic/dsc_device.sv
// Contract
// R1: reset pin forces all state default
// R2: nothing starts before reset released
// R3: host pulses reset after supply up
// R4: low core supply holds defaults
// R5: host waits power-up delay after reset
// R6: three master clock sources selectable
// R7: new clock source applied at stop
// R8: host waits after clock source switch
// R9: rc oscillator allows bypass path only
// R10: rc oscillator blocks playback, impedance measure
// R11: sysclk out from crystal or pll
// R12: main port takes i2s, tdm, packed
// R13: aux port takes packed stream only
// R14: one-bit interface 128x, shares aux pins
// R15: interrupt when status set and unmasked
// R16: headphone insertion raises interrupt event
// R17: impedance measure started, events report progress
// R18: host powers down before reconfiguring
// R19: power-down bit gates playback chain
// R20: host configures before clearing power-down
// R21: host sets power-down before chain changes
// R22: status latched until read, int held
// R23: transactions ignored while delays run
`timescale 1ns/1ps
module dsc_device #(
  parameter int unsigned PUD_CYC    = dsc_pkg::PUD_CYC,
  parameter int unsigned SWITCH_CYC = dsc_pkg::SWITCH_CYC
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  dsc_link_if.dev         link,
  input  wire logic       core_supply_ok_i,
  input  wire logic       hp_present_i,
  input  wire logic [7:0] imp_sample_i,
  output logic            playback_chain_enable_o,
  output logic            bypass_path_enable_o,
  output logic [1:0]      master_clock_source_o,
  output logic            sysclk_from_pll_o,
  output logic [1:0]      main_port_format_o,
  output logic            aux_one_bit_direct_o,
  output logic            one_bit_rate_128_o,
  output logic            imp_measure_active_o
);
  localparam int unsigned CW = dsc_pkg::CNT_W;

  // ---------------------------------------------------------------------------
  // input synchronisers and edges
  // ---------------------------------------------------------------------------
  logic [5:0] s_w;
  logic       rst_all_w;
  logic       lclk_q;
  logic       frm_q;
  logic       hp_q;

  dsc_sync #(.WIDTH(6)) u_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   ({link.reset_n, link.link_clk, link.frame, link.mosi,
             core_supply_ok_i, hp_present_i}),
    .q_o   (s_w)
  );

  assign rst_all_w = rst_i | ~s_w[5] | ~s_w[1]; // R1 R4

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      lclk_q <= 1'b0;
      frm_q  <= 1'b0;
      hp_q   <= 1'b0;
    end else begin
      lclk_q <= s_w[4];
      frm_q  <= s_w[3];
      hp_q   <= s_w[0];
    end
  end

  // ---------------------------------------------------------------------------
  // power-up and clock switch delays
  // ---------------------------------------------------------------------------
  logic [CW-1:0] pud_q;
  logic [CW-1:0] sw_q;
  logic          ready_w;
  logic          apply_w;
  logic          pendv_q;
  logic [1:0]    pend_q;
  logic          frame_fall_w;

  assign ready_w      = (pud_q == '0) && (sw_q == '0); // R2 R23
  assign frame_fall_w = ~s_w[3] & frm_q;
  assign apply_w      = frame_fall_w & pendv_q; // R7

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      pud_q <= CW'(PUD_CYC); // R2
      sw_q  <= '0;
    end else begin
      if (pud_q != '0) pud_q <= pud_q - 1'b1;
      if (apply_w) sw_q <= CW'(SWITCH_CYC);
      else if (sw_q != '0) sw_q <= sw_q - 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // link frame: rw, 7-bit address, 8-bit data, msb first
  // ---------------------------------------------------------------------------
  logic [4:0]  bit_q;
  logic [14:0] sr_q;
  logic        drop_q;
  logic        miso_q;
  logic [6:0]  rsh_q;
  logic        rise_w;
  logic [6:0]  addr_w;
  logic        rd_ev_w;
  logic        wr_w;
  logic [6:0]  wa_w;
  logic [7:0]  wd_w;
  logic [7:0]  rd_w;

  assign rise_w  = s_w[4] & ~lclk_q & s_w[3] & ~drop_q & (bit_q < 5'(dsc_pkg::FRAME_BITS));
  assign addr_w  = {sr_q[5:0], s_w[2]};
  assign rd_ev_w = rise_w & (bit_q == 5'h07) & sr_q[6];
  assign wr_w    = rise_w & (bit_q == 5'h0f) & ~sr_q[14];
  assign wa_w    = sr_q[13:7];
  assign wd_w    = {sr_q[6:0], s_w[2]};

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      bit_q  <= '0;
      sr_q   <= '0;
      drop_q <= 1'b1;
      miso_q <= 1'b0;
      rsh_q  <= '0;
    end else if (s_w[3] & ~frm_q) begin
      bit_q  <= '0;
      drop_q <= ~ready_w; // R23
    end else if (rise_w) begin
      sr_q  <= {sr_q[13:0], s_w[2]};
      bit_q <= bit_q + 1'b1;
      if (bit_q == 5'h07) {miso_q, rsh_q} <= rd_w;
      else if (bit_q > 5'h07) {miso_q, rsh_q} <= {rsh_q, 1'b0};
    end
  end

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  logic [2:0] pwr_q;
  logic [1:0] src_q;
  logic       syspll_q;
  logic [1:0] fmt_q;
  logic       aux_q;
  logic       r128_q;
  logic [2:0] mask_q;
  logic [2:0] stat_q;
  logic [2:0] ev_w;
  logic [2:0] clr_w;

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      pwr_q    <= dsc_pkg::PWR_RST;
      pend_q   <= dsc_pkg::SRC_EXT;
      pendv_q  <= 1'b0;
      src_q    <= dsc_pkg::SRC_EXT;
      syspll_q <= 1'b0;
      mask_q   <= dsc_pkg::MASK_RST;
    end else begin
      if (wr_w && wa_w == dsc_pkg::A_PWR) pwr_q <= wd_w[2:0];
      if (wr_w && wa_w == dsc_pkg::A_IMASK) mask_q <= wd_w[2:0];
      if (wr_w && wa_w == dsc_pkg::A_CLK) begin
        syspll_q <= wd_w[dsc_pkg::CLK_SYSPLL]; // R11
        if (wd_w[1:0] != dsc_pkg::SRC_BAD) begin
          pend_q  <= wd_w[1:0]; // R6
          pendv_q <= 1'b1;
        end
      end else if (apply_w) begin
        src_q   <= pend_q; // R7
        pendv_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      fmt_q  <= '0;
      aux_q  <= 1'b0;
      r128_q <= 1'b0;
    end else if (wr_w && wa_w == dsc_pkg::A_SER && wd_w[1:0] != dsc_pkg::FMT_BAD) begin
      fmt_q  <= wd_w[1:0]; // R12
      aux_q  <= wd_w[2]; // R13 R14
      r128_q <= wd_w[3]; // R14
    end
  end

  // ---------------------------------------------------------------------------
  // impedance measurement
  // ---------------------------------------------------------------------------
  logic       run_q;
  logic [1:0] ph_q;
  logic [9:0] icnt_q;
  logic [6:0] freq_q;
  logic [7:0] ires_q;
  logic       start_w;
  logic       tick_w;

  assign start_w = wr_w & (wa_w == dsc_pkg::A_IMP) & wd_w[dsc_pkg::IMP_START] & ~run_q
                 & (src_q != dsc_pkg::SRC_OSC); // R10 R17
  assign tick_w  = run_q & (icnt_q == 10'(dsc_pkg::IMP_PHASE_CYC - 1));

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      run_q  <= 1'b0;
      ph_q   <= '0;
      icnt_q <= '0;
      freq_q <= '0;
      ires_q <= '0;
    end else if (start_w) begin
      run_q  <= 1'b1;
      ph_q   <= '0;
      icnt_q <= '0;
      freq_q <= wd_w[6:0];
    end else if (run_q && src_q == dsc_pkg::SRC_OSC) begin
      run_q <= 1'b0; // R10
    end else if (tick_w) begin
      icnt_q <= '0;
      ph_q   <= ph_q + 1'b1;
      if (ph_q == 2'h3) begin
        run_q  <= 1'b0;
        ires_q <= imp_sample_i;
      end
    end else if (run_q) begin
      icnt_q <= icnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt status, read-back and outputs
  // ---------------------------------------------------------------------------
  logic int_oe_q;
  logic play_q;
  logic byp_q;

  assign ev_w  = {tick_w & (ph_q == 2'h3), tick_w & (ph_q != 2'h3), s_w[0] & ~hp_q}; // R16 R17
  assign clr_w = (rd_ev_w && addr_w == dsc_pkg::A_ISTAT) ? 3'h7 : 3'h0;
  assign rd_w  = (addr_w == dsc_pkg::A_PWR)   ? {5'h00, pwr_q} :
                 (addr_w == dsc_pkg::A_CLK)   ? {5'h00, syspll_q, src_q} :
                 (addr_w == dsc_pkg::A_ISTAT) ? {5'h00, stat_q} :
                 (addr_w == dsc_pkg::A_IMASK) ? {5'h00, mask_q} :
                 (addr_w == dsc_pkg::A_IMP)   ? {run_q, freq_q} :
                 (addr_w == dsc_pkg::A_IRES)  ? ires_q :
                 (addr_w == dsc_pkg::A_STAT)  ? {3'h0, s_w[0], run_q, src_q, play_q} :
                 (addr_w == dsc_pkg::A_SER)   ? {4'h0, r128_q, aux_q, fmt_q} : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (rst_all_w) begin
      stat_q   <= '0;
      int_oe_q <= 1'b0;
      play_q   <= 1'b0;
      byp_q    <= 1'b0;
    end else begin
      stat_q   <= (stat_q & ~clr_w) | ev_w; // R22
      int_oe_q <= |(stat_q & ~mask_q); // R15 R22
      play_q   <= ~pwr_q[dsc_pkg::PWR_PDN] & (src_q != dsc_pkg::SRC_OSC); // R19 R10
      byp_q    <= pwr_q[dsc_pkg::PWR_BYP] & pwr_q[dsc_pkg::PWR_PDN]; // R9
    end
  end

  assign link.miso               = miso_q;
  assign link.int_n_o            = 1'b0;
  assign link.int_n_oe           = int_oe_q;
  assign playback_chain_enable_o = play_q;
  assign bypass_path_enable_o    = byp_q;
  assign master_clock_source_o   = src_q;
  assign sysclk_from_pll_o       = syspll_q;
  assign main_port_format_o      = fmt_q;
  assign aux_one_bit_direct_o    = aux_q;
  assign one_bit_rate_128_o      = r128_q;
  assign imp_measure_active_o    = run_q;
endmodule

// ### logic/dsc_host.sv
`timescale 1ns/1ps
module dsc_host #(
  parameter int unsigned PUD_CYC    = dsc_pkg::PUD_CYC,
  parameter int unsigned SWITCH_CYC = dsc_pkg::SWITCH_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  dsc_link_if.host         link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  localparam int unsigned CW = dsc_pkg::CNT_W;

  // ---------------------------------------------------------------------------
  // request decode and command checks
  // ---------------------------------------------------------------------------
  dsc_pkg::dsc_host_state_type state_q;
  logic [1:0]    s_w;
  logic [CW-1:0] cnt_q;
  logic [2:0]    div_q;
  logic [5:0]    step_q;
  logic [15:0]   cmd_q;
  logic [15:0]   sh_q;
  logic [7:0]    rd_q;
  logic [2:0]    pwr_q;
  logic          cfg_q;
  logic          ref_q;
  logic          rstn_q;
  logic          lclk_q;
  logic          frm_q;
  logic          mosi_q;
  logic          ack_q;
  logic [31:0]   dat_q;
  logic          req_w;
  logic          cmd_w;
  logic          ctrl_w;
  logic          refuse_w;
  logic          clkwr_w;
  logic [31:0]   rdmux_w;

  dsc_sync #(.WIDTH(2)) u_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   ({link.miso, link.int_n}),
    .q_o   (s_w)
  );

  assign req_w    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign cmd_w    = req_w & wb_we_i & (wb_adr_i == dsc_pkg::WB_CMD) & (&wb_sel_i[1:0]);
  assign ctrl_w   = req_w & wb_we_i & (wb_adr_i == dsc_pkg::WB_CTRL) & wb_sel_i[0] & wb_dat_i[0];
  assign refuse_w = ~wb_dat_i[15] & (
                    ((wb_dat_i[14:8] == dsc_pkg::A_SER) & ~pwr_q[dsc_pkg::PWR_PDN]) | // R21
                    ((wb_dat_i[14:8] == dsc_pkg::A_CLK) & pwr_q[dsc_pkg::PWR_PLL]) | // R18
                    ((wb_dat_i[14:8] == dsc_pkg::A_PWR) & ~wb_dat_i[dsc_pkg::PWR_PDN]
                     & ~cfg_q)); // R20
  assign clkwr_w  = ~cmd_q[15] & (cmd_q[14:8] == dsc_pkg::A_CLK);

  // ---------------------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ctrl_w) begin
      state_q <= dsc_pkg::H_RESET; // R3
      cnt_q   <= CW'(dsc_pkg::RST_HOLD_CYC);
      rstn_q  <= 1'b0;
      lclk_q  <= 1'b0;
      frm_q   <= 1'b0;
      mosi_q  <= 1'b0;
      step_q  <= '0;
      div_q   <= '0;
      sh_q    <= '0;
    end else begin
      case (state_q)
        dsc_pkg::H_RESET: begin
          if (cnt_q == '0) begin
            rstn_q  <= 1'b1;
            cnt_q   <= CW'(PUD_CYC + dsc_pkg::MARGIN_CYC); // R5
            state_q <= dsc_pkg::H_WAIT;
          end else cnt_q <= cnt_q - 1'b1;
        end
        dsc_pkg::H_WAIT: begin
          if (cnt_q == '0) state_q <= dsc_pkg::H_IDLE;
          else cnt_q <= cnt_q - 1'b1;
        end
        dsc_pkg::H_IDLE: begin
          if (cmd_w && !refuse_w) begin
            sh_q    <= wb_dat_i[15:0];
            mosi_q  <= wb_dat_i[15];
            frm_q   <= 1'b1;
            step_q  <= '0;
            div_q   <= 3'(dsc_pkg::HALF_CYC - 1);
            state_q <= dsc_pkg::H_RUN;
          end
        end
        dsc_pkg::H_RUN: begin
          if (div_q != '0) div_q <= div_q - 1'b1;
          else begin
            div_q  <= 3'(dsc_pkg::HALF_CYC - 1);
            step_q <= step_q + 1'b1;
            if (step_q == 6'h20) begin
              frm_q   <= 1'b0;
              cnt_q   <= clkwr_w ? CW'(SWITCH_CYC + dsc_pkg::MARGIN_CYC) // R8
                                 : CW'(dsc_pkg::GAP_CYC);
              state_q <= dsc_pkg::H_WAIT;
            end else if (!step_q[0]) begin
              lclk_q <= 1'b1;
            end else begin
              lclk_q <= 1'b0;
              sh_q   <= {sh_q[14:0], 1'b0};
              mosi_q <= sh_q[14];
            end
          end
        end
        default: state_q <= dsc_pkg::H_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // command bookkeeping
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ctrl_w) begin
      cmd_q <= '0;
      pwr_q <= dsc_pkg::PWR_RST;
      cfg_q <= 1'b0;
      ref_q <= 1'b0;
      rd_q  <= '0;
    end else begin
      if (cmd_w && state_q == dsc_pkg::H_IDLE) begin
        ref_q <= refuse_w;
        if (!refuse_w) begin
          cmd_q <= wb_dat_i[15:0];
          if (!wb_dat_i[15] && wb_dat_i[14:8] == dsc_pkg::A_PWR) pwr_q <= wb_dat_i[2:0];
          if (!wb_dat_i[15] && wb_dat_i[14:8] == dsc_pkg::A_SER) cfg_q <= 1'b1;
        end
      end
      if (state_q == dsc_pkg::H_RUN && div_q == '0 && !step_q[0] && step_q >= 6'h10
          && step_q < 6'h20)
        rd_q <= {rd_q[6:0], s_w[1]}; // R17
    end
  end

  // ---------------------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------------------
  assign rdmux_w = (wb_adr_i == dsc_pkg::WB_CMD)  ? {16'h0000, cmd_q} :
                   (wb_adr_i == dsc_pkg::WB_STAT) ? {16'h0000, rd_q, 5'h00, ref_q, ~s_w[0],
                                                     state_q == dsc_pkg::H_IDLE} :
                   32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req_w;
      dat_q <= rdmux_w;
    end
  end

  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = dat_q;
  assign link.reset_n  = rstn_q;
  assign link.link_clk = lclk_q;
  assign link.frame    = frm_q;
  assign link.mosi     = mosi_q;
endmodule

// ### tb/dsc_link_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// link checker
// ---------------------------------------------------------------------------
module dsc_link_props #(
  parameter int unsigned PUD_CYC = dsc_pkg::PUD_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic reset_n,
  input  wire logic link_clk,
  input  wire logic frame,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic int_n_o,
  input  wire logic int_n_oe,
  input  wire logic int_n
);
  int unsigned pud_q;
  logic [4:0]  bits_q;
  logic [4:0]  quiet_q;
  logic        clk_q;

  // ---------------------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    clk_q <= link_clk;
  end
  // cycles since the device reset line went high
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !reset_n) pud_q <= 0;
    else if (pud_q < PUD_CYC) pud_q <= pud_q + 1;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !frame) bits_q <= 5'h00;
    else if (link_clk && !clk_q) bits_q <= bits_q + 5'h01;
  end
  // saturating idle time since the last frame
  always_ff @(posedge core_clk_i) begin
    if (rst_i || frame) quiet_q <= 5'h00;
    else if (quiet_q != 5'h1f) quiet_q <= quiet_q + 5'h01;
  end

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_lead;
    !link_clk [*4];
  endsequence
  sequence s_rst_low;
    !reset_n [*6];
  endsequence

  chk_reset_hold: assert property ($fell(rst_i) |-> !reset_n [*8])
    else $error("device reset released too soon");
  chk_no_early: assert property (!reset_n |-> !frame)
    else $error("frame while device held in reset");
  chk_pud_wait: assert property ($rose(frame) |-> pud_q >= PUD_CYC)
    else $error("frame before power-up delay");
  chk_int_reset: assert property (s_rst_low |-> !int_n_oe)
    else $error("interrupt driven during reset");
  chk_miso_reset: assert property (s_rst_low |-> !miso)
    else $error("read data driven during reset");
  chk_frame_lead: assert property ($rose(frame) |-> s_lead ##[1:8] link_clk)
    else $error("bad frame start");
  chk_mosi_hold: assert property (link_clk |-> $stable(mosi))
    else $error("data moved while link clock high");
  chk_bit_count: assert property ($fell(frame) |-> bits_q == 5'd16)
    else $error("frame not sixteen bits");
  chk_int_release: assert property ($rose(int_n) |-> frame || !reset_n)
    else $error("interrupt released outside a link frame");
  chk_int_held: assert property (!int_n && quiet_q == 5'h1f && reset_n |=> !int_n)
    else $error("interrupt dropped without a read");
endmodule

// ### tb/dac_system_control_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module dac_system_control_bench;
  localparam int unsigned PUD = 200;
  localparam int unsigned SW  = 50;
  logic        core_clk_i;
  logic        rst_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, st;
  logic        core_supply_ok_i, hp_present_i;
  logic [7:0]  imp_sample_i;
  logic        playback_chain_enable_o, bypass_path_enable_o, sysclk_from_pll_o;
  logic [1:0]  master_clock_source_o, main_port_format_o;
  logic        aux_one_bit_direct_o, one_bit_rate_128_o, imp_measure_active_o;
  int          miscompares, tests_run;

  dsc_link_if link_if ();
  dsc_host #(.PUD_CYC(PUD), .SWITCH_CYC(SW)) u_dsc_host (.core_clk_i, .rst_i,
    .link(link_if.host), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  dsc_device #(.PUD_CYC(PUD), .SWITCH_CYC(SW)) u_dsc_device (.core_clk_i, .rst_i,
    .link(link_if.dev), .core_supply_ok_i, .hp_present_i, .imp_sample_i,
    .playback_chain_enable_o, .bypass_path_enable_o, .master_clock_source_o,
    .sysclk_from_pll_o, .main_port_format_o, .aux_one_bit_direct_o,
    .one_bit_rate_128_o, .imp_measure_active_o);
  dsc_link_props #(.PUD_CYC(PUD)) u_props (.core_clk_i, .rst_i,
    .reset_n(link_if.reset_n), .link_clk(link_if.link_clk), .frame(link_if.frame),
    .mosi(link_if.mosi), .miso(link_if.miso), .int_n_o(link_if.int_n_o),
    .int_n_oe(link_if.int_n_oe), .int_n(link_if.int_n));

  // ---------------------------------------------------------------------------
  // bus helpers
  // ---------------------------------------------------------------------------
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin @(posedge core_clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin wb(1'b0, dsc_pkg::WB_STAT, 32'h0, s); n++; end
    while (s[0] !== 1'b1 && n < 3000);
    if (n == 3000) miscompares++;
  endtask
  // one link transaction, leaves the status word in st
  task automatic cmd(input logic r, input logic [6:0] a, input logic [7:0] d);
    logic [31:0] s;
    wait_idle();
    wb(1'b1, dsc_pkg::WB_CMD, {16'h0, r, a, d}, s);
    wait_idle();
    wb(1'b0, dsc_pkg::WB_STAT, 32'h0, st);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_defaults();
    logic [31:0] s;
    wait_idle();
    wb(1'b0, 4'hc, 32'h0, s);
    `CHK(s, 32'h0)
    cmd(1'b1, dsc_pkg::A_PWR, 8'h00);
    `CHK(st[15:8], 8'h01)
    cmd(1'b1, dsc_pkg::A_IMASK, 8'h00);
    `CHK(st[15:8], 8'h07)
    `CHK(playback_chain_enable_o, 1'b0)
    `CHK(master_clock_source_o, dsc_pkg::SRC_EXT)
  endtask
  task automatic t_playback();
    cmd(1'b0, dsc_pkg::A_PWR, 8'h00);
    `CHK(st[2], 1'b1)
    `CHK(playback_chain_enable_o, 1'b0)
    for (int f = 0; f < 3; f++) begin
      cmd(1'b0, dsc_pkg::A_SER, 8'h0c | 8'(f));
      `CHK(main_port_format_o, 2'(f))
      `CHK(aux_one_bit_direct_o, 1'b1)
      `CHK(one_bit_rate_128_o, 1'b1)
    end
    cmd(1'b0, dsc_pkg::A_SER, 8'h03);
    `CHK(main_port_format_o, 2'h2)
    cmd(1'b0, dsc_pkg::A_PWR, 8'h00);
    `CHK(playback_chain_enable_o, 1'b1)
    cmd(1'b0, dsc_pkg::A_SER, 8'h00);
    `CHK(st[2], 1'b1)
    `CHK(main_port_format_o, 2'h2)
    cmd(1'b0, dsc_pkg::A_PWR, 8'h01);
    `CHK(playback_chain_enable_o, 1'b0)
  endtask
  task automatic t_clock();
    cmd(1'b0, dsc_pkg::A_CLK, 8'h05);
    `CHK(master_clock_source_o, dsc_pkg::SRC_PLL)
    `CHK(sysclk_from_pll_o, 1'b1)
    cmd(1'b0, dsc_pkg::A_CLK, 8'h03);
    `CHK(master_clock_source_o, dsc_pkg::SRC_PLL)
    `CHK(sysclk_from_pll_o, 1'b0)
    cmd(1'b0, dsc_pkg::A_CLK, 8'h02);
    `CHK(master_clock_source_o, dsc_pkg::SRC_OSC)
    cmd(1'b0, dsc_pkg::A_PWR, 8'h00);
    `CHK(playback_chain_enable_o, 1'b0)
    cmd(1'b0, dsc_pkg::A_IMP, 8'h85);
    `CHK(imp_measure_active_o, 1'b0)
    cmd(1'b0, dsc_pkg::A_PWR, 8'h05);
    `CHK(bypass_path_enable_o, 1'b1)
    cmd(1'b0, dsc_pkg::A_PWR, 8'h03);
    cmd(1'b0, dsc_pkg::A_CLK, 8'h00);
    `CHK(st[2], 1'b1)
    `CHK(master_clock_source_o, dsc_pkg::SRC_OSC)
    cmd(1'b0, dsc_pkg::A_PWR, 8'h01);
    cmd(1'b0, dsc_pkg::A_CLK, 8'h00);
    `CHK(master_clock_source_o, dsc_pkg::SRC_EXT)
  endtask
  task automatic t_irq();
    hp_present_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    `CHK(link_if.int_n, 1'b1)
    cmd(1'b0, dsc_pkg::A_IMASK, 8'h06);
    `CHK(link_if.int_n, 1'b0)
    `CHK(st[1], 1'b1)
    repeat (100) @(posedge core_clk_i);
    `CHK(link_if.int_n, 1'b0)
    cmd(1'b1, dsc_pkg::A_ISTAT, 8'h00);
    `CHK(st[15:8], 8'h01)
    `CHK(link_if.int_n, 1'b1)
  endtask
  task automatic t_imp();
    int n;
    imp_sample_i <= 8'h5a;
    cmd(1'b0, dsc_pkg::A_IMASK, 8'h00);
    cmd(1'b0, dsc_pkg::A_IMP, 8'h85);
    `CHK(imp_measure_active_o, 1'b1)
    n = 0;
    while (imp_measure_active_o === 1'b1 && n < 6000) begin @(posedge core_clk_i); n++; end
    `CHK(imp_measure_active_o, 1'b0)
    cmd(1'b1, dsc_pkg::A_IRES, 8'h00);
    `CHK(st[15:8], 8'h5a)
    cmd(1'b1, dsc_pkg::A_ISTAT, 8'h00);
    `CHK(st[15:8], 8'h06)
    `CHK(link_if.int_n, 1'b1)
  endtask
  task automatic t_supply();
    logic [31:0] s;
    cmd(1'b0, dsc_pkg::A_PWR, 8'h00);
    `CHK(playback_chain_enable_o, 1'b1)
    core_supply_ok_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    `CHK(playback_chain_enable_o, 1'b0)
    `CHK(main_port_format_o, 2'h0)
    core_supply_ok_i <= 1'b1;
    wb(1'b1, dsc_pkg::WB_CTRL, 32'h1, s);
    cmd(1'b1, dsc_pkg::A_PWR, 8'h00);
    `CHK(st[15:8], 8'h01)
  endtask

  // ---------------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    #(60000 * 8);
    miscompares++;
    stop_test();
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    core_supply_ok_i = 1'b1;
    hp_present_i = 1'b0;
    imp_sample_i = 8'h00;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_playback();
    t_clock();
    t_irq();
    t_imp();
    t_supply();
    stop_test();
  end
endmodule
